// >>> src/sdr_pkg.sv
/*
 * Constants shared by the DRAM-side refresh, self-refresh and write-mask
 * block: command encodings, mode field codes, register map and timings.
 * Assumes a 100 MHz system clock that samples the memory clock pin.
 */
// Notes on behaviour
// RULE_01: One mask bit per data byte, writes only
// RULE_02: Burst chop or eight beats from mode field
// RULE_03: Controller waits write-to-read after last beat
// RULE_04: Controller waits write recovery before precharge
// RULE_05: Refresh decoded from select, strobes, write high
// RULE_06: Controller precharges all banks before refresh
// RULE_07: Refresh uses internal row counter, leaves idle
// RULE_08: Only idle commands during refresh cycle time
// RULE_09: At most eight refreshes postponed
// RULE_10: At most eight refreshes pulled in
// RULE_11: At most sixteen refreshes per two intervals
// RULE_12: Owed count frozen across self-refresh
// RULE_13: Self-refresh entry decoded with clock enable low
// RULE_14: Controller turns termination off before entry
// RULE_15: Controller holds clock enable low, minimum residency
// RULE_16: Delay loop off on entry, reset on exit
// RULE_17: In self-refresh refresh from own timer
// RULE_18: No write within 512 clocks after exit
// RULE_19: Clock may stop after entry, restart before exit
// RULE_20: Controller waits exit delays after exit
// RULE_21: Idle commands and termination off after exit
// RULE_22: One extra refresh before re-entering self-refresh
// RULE_23: Controller tracks signed owed refresh count
package sdr_pkg;
    // Command field {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_REFRESH = 4'h1;
    localparam logic [3:0] CMD_WRITE = 4'h4;
    localparam logic [3:0] CMD_READ = 4'h5;
    localparam logic [3:0] CMD_NOP = 4'h7;
    // Burst-length field codes
    localparam logic [1:0] BL_FIXED8 = 2'h0;
    localparam logic [1:0] BL_OTF = 2'h1;
    localparam logic [1:0] BL_CHOP4 = 2'h2;
    localparam int BEATS_CHOP = 4;
    localparam int BEATS_EIGHT = 8;
    localparam int DATA_W = 16;
    localparam int MASK_W = DATA_W / 8;
    localparam int ROW_W = 14;
    localparam int WRITE_LAT = 5;
    // Register byte offsets
    localparam logic [3:0] OFS_MODE0 = 4'h0;
    localparam logic [3:0] OFS_MODE1 = 4'h4;
    localparam logic [3:0] OFS_STATUS = 4'h8;
    localparam logic [3:0] OFS_COUNT = 4'hc;
    localparam logic [31:0] MODE0_RST = 32'h0;
    localparam logic [31:0] MODE1_RST = 32'h0;
    // Status bit positions
    localparam int ST_SELF = 0;
    localparam int ST_DLL = 1;
    localparam int ST_RFBUSY = 2;
    localparam int ST_WBUSY = 3;
    // Timing in ns, converted to 10 ns clock cycles
    localparam int CLK_NS = 10;
    localparam int REFI_NS = 7800;
    localparam int RFC_NS = 160;
    localparam int CKE_NS = 5;
    localparam int REFI_CYC = REFI_NS / CLK_NS;
    localparam int RFC_CYC = (RFC_NS + CLK_NS - 1) / CLK_NS;
    localparam int CKE_CYC_RAW = CKE_NS / CLK_NS;
    localparam int CKE_CYC = (CKE_CYC_RAW < 1) ? 1 : CKE_CYC_RAW;
    localparam int DLL_RESET_NCK = 512;
endpackage : sdr_pkg

// >>> src/sdr_refresh.sv
/*
 * DRAM-side logic: command decode from sampled pins, refresh row counter,
 * self-refresh timer with delay-loop control, and write-burst mask capture.
 * Assumes memory clock and command pins come from another domain; they are
 * synchronised and the memory clock's rising edge is found by sampling.
 */
// Added by the designer: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
module sdr_refresh (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic mem_clk_i,
    input wire logic chip_select_n_i,
    input wire logic row_strobe_n_i,
    input wire logic column_strobe_n_i,
    input wire logic write_enable_n_i,
    input wire logic clock_enable_pin_i,
    input wire logic burst_select_address_bit_i,
    input wire logic [sdr_pkg::DATA_W-1:0] data_i,
    input wire logic [sdr_pkg::MASK_W-1:0] write_data_mask_i,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic refresh_pulse_o,
    output logic [sdr_pkg::ROW_W-1:0] refresh_row_o,
    output logic self_refresh_o,
    output logic dll_enabled_o,
    output logic wr_beat_valid_o,
    output logic [sdr_pkg::DATA_W-1:0] wr_beat_data_o,
    output logic [sdr_pkg::MASK_W-1:0] wr_beat_mask_o
);
    import sdr_pkg::*;

    typedef enum logic [1:0] {
        SDR_IDLE = 2'b00,
        SDR_REFRESH = 2'b01,
        SDR_SELF = 2'b10
    } sdr_state_e;

    localparam int SYNC_W = 8 + DATA_W + MASK_W;

    // Beats in a burst from mode field and on-the-fly bit
    function automatic logic [3:0] burst_beats(input logic [1:0] fld,
                                               input logic sel);
        if (fld == BL_CHOP4 || (fld == BL_OTF && !sel))
            return 4'(BEATS_CHOP);
        return 4'(BEATS_EIGHT);
    endfunction : burst_beats

    // Two-stage synchroniser on every pin input
    logic [SYNC_W-1:0] sync1_reg;
    logic [SYNC_W-1:0] sync2_reg;
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= {mem_clk_i, chip_select_n_i, row_strobe_n_i,
                          column_strobe_n_i, write_enable_n_i,
                          clock_enable_pin_i, burst_select_address_bit_i,
                          1'b0, data_i, write_data_mask_i};
            sync2_reg <= sync1_reg;
        end
    end

    logic ck_s;
    logic [3:0] cmd_s;
    logic cke_s;
    logic bsel_s;
    logic [DATA_W-1:0] dq_s;
    logic [MASK_W-1:0] dm_s;
    assign ck_s = sync2_reg[SYNC_W-1];
    assign cmd_s = sync2_reg[SYNC_W-2 -: 4];
    assign cke_s = sync2_reg[SYNC_W-6];
    assign bsel_s = sync2_reg[SYNC_W-7];
    assign dq_s = sync2_reg[MASK_W +: DATA_W];
    assign dm_s = sync2_reg[MASK_W-1:0];

    // Memory clock edge detect on the synchronised copy
    logic ck_prev_reg;
    logic cke_prev_reg;
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ck_prev_reg <= 1'b0;
            cke_prev_reg <= 1'b0;
        end else begin
            ck_prev_reg <= ck_s;
            if (ck_s && !ck_prev_reg)
                cke_prev_reg <= cke_s;
        end
    end
    logic ck_rise;
    assign ck_rise = ck_s && !ck_prev_reg;

    // Command decode; clock enable previous-high / now-low marks entry
    logic is_refresh;
    logic is_self_entry;
    logic is_write;
    // RULE_05: refresh command decode
    assign is_refresh = ck_rise && cmd_s == CMD_REFRESH && cke_s;
    // RULE_13: self-refresh entry decode
    assign is_self_entry = ck_rise && cmd_s == CMD_REFRESH && !cke_s &&
                           cke_prev_reg;
    assign is_write = ck_rise && cke_s && cmd_s == CMD_WRITE;

    // Register file
    logic [31:0] mode0_reg;
    logic [31:0] mode1_reg;
    logic [1:0] state_reg;
    sdr_state_e state;
    assign state = sdr_state_e'(state_reg);
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mode0_reg <= MODE0_RST;
            mode1_reg <= MODE1_RST;
        end else if (avs_write) begin
            if (avs_address == OFS_MODE0)
                mode0_reg <= avs_writedata;
            if (avs_address == OFS_MODE1)
                mode1_reg <= avs_writedata;
        end
    end

    // Self-refresh timer, refresh cycle counter and state machine
    logic [15:0] timer_reg;
    logic [15:0] rfc_reg;
    logic [ROW_W-1:0] row_reg;
    logic [15:0] refcnt_reg;
    logic int_ref;
    // RULE_17: first internal refresh within gate pulse, then interval
    assign int_ref = state == SDR_SELF && timer_reg == 16'h0;
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_reg <= SDR_IDLE;
            timer_reg <= 16'h0;
            rfc_reg <= 16'h0;
        end else begin
            case (state)
                SDR_IDLE: begin
                    if (is_refresh) begin
                        state_reg <= SDR_REFRESH;
                        rfc_reg <= 16'(RFC_CYC - 1);
                    end else if (is_self_entry) begin
                        state_reg <= SDR_SELF;
                        timer_reg <= 16'(CKE_CYC - 1);
                    end
                end
                SDR_REFRESH: begin
                    // RULE_07: banks return to precharged idle
                    if (rfc_reg == 16'h0)
                        state_reg <= SDR_IDLE;
                    else
                        rfc_reg <= rfc_reg - 16'h1;
                end
                SDR_SELF: begin
                    // RULE_17: only clock enable ends self-refresh
                    if (cke_s) begin
                        state_reg <= SDR_IDLE;
                    end else if (timer_reg == 16'h0) begin
                        timer_reg <= 16'(REFI_CYC - 1);
                    end else begin
                        timer_reg <= timer_reg - 16'h1;
                    end
                end
                default: state_reg <= SDR_IDLE;
            endcase
        end
    end

    // RULE_07: row address from internal counter, address bus ignored
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            row_reg <= '0;
            refcnt_reg <= 16'h0;
            refresh_pulse_o <= 1'b0;
        end else begin
            refresh_pulse_o <= (state == SDR_IDLE && is_refresh) || int_ref;
            if ((state == SDR_IDLE && is_refresh) || int_ref) begin
                row_reg <= row_reg + 1'b1;
                refcnt_reg <= refcnt_reg + 16'h1;
            end
        end
    end
    assign refresh_row_o = row_reg;

    // RULE_16: loop off on entry, back on with reset count on exit
    logic dll_on_reg;
    logic [9:0] dll_rst_reg;
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            dll_on_reg <= 1'b0;
            dll_rst_reg <= 10'h0;
        end else if (mode1_reg[0]) begin
            dll_on_reg <= 1'b0;
        end else if (state == SDR_IDLE && is_self_entry) begin
            dll_on_reg <= 1'b0;
        end else if (state == SDR_SELF && cke_s) begin
            dll_rst_reg <= 10'(DLL_RESET_NCK - 1);
        end else if (dll_rst_reg != 10'h0) begin
            if (ck_rise)
                dll_rst_reg <= dll_rst_reg - 10'h1;
        end else if (state != SDR_SELF) begin
            dll_on_reg <= 1'b1;
        end
    end

    // Write burst tracker: latency then beats, mask captured with data
    logic [3:0] wlat_reg;
    logic [3:0] beats_reg;
    logic [3:0] pend_beats_reg;
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wlat_reg <= 4'h0;
            beats_reg <= 4'h0;
            pend_beats_reg <= 4'h0;
            wr_beat_valid_o <= 1'b0;
            wr_beat_data_o <= '0;
            wr_beat_mask_o <= '0;
        end else begin
            wr_beat_valid_o <= 1'b0;
            if (state == SDR_IDLE && is_write) begin
                // Loaded one short: first beat lands on the latency-th edge
                wlat_reg <= 4'(WRITE_LAT - 1);
                // RULE_02: beat count from mode field and select bit
                pend_beats_reg <= burst_beats(mode0_reg[1:0], bsel_s);
            end else if (ck_rise && wlat_reg != 4'h0) begin
                wlat_reg <= wlat_reg - 4'h1;
                if (wlat_reg == 4'h1)
                    beats_reg <= pend_beats_reg;
            end else if (ck_rise && beats_reg != 4'h0) begin
                // RULE_01: one mask bit per byte, same timing as data
                beats_reg <= beats_reg - 4'h1;
                wr_beat_valid_o <= 1'b1;
                wr_beat_data_o <= dq_s;
                wr_beat_mask_o <= dm_s;
            end
        end
    end

    assign self_refresh_o = state == SDR_SELF;
    assign dll_enabled_o = dll_on_reg;

    // Bus slave: zero wait states, unmapped reads return zero
    assign avs_waitrequest = 1'b0;
    always_comb begin
        avs_readdata = 32'h0;
        case (avs_address)
            OFS_MODE0: avs_readdata = mode0_reg;
            OFS_MODE1: avs_readdata = mode1_reg;
            OFS_STATUS: begin
                avs_readdata[ST_SELF] = state == SDR_SELF;
                avs_readdata[ST_DLL] = dll_on_reg;
                avs_readdata[ST_RFBUSY] = state == SDR_REFRESH;
                avs_readdata[ST_WBUSY] = beats_reg != 4'h0 ||
                                         wlat_reg != 4'h0;
            end
            OFS_COUNT: avs_readdata = {16'h0, refcnt_reg};
            default: avs_readdata = 32'h0;
        endcase
    end
endmodule : sdr_refresh

// >>> tb/sdr_ctl_model.sv
/* Memory controller model: memory clock, command pins, data and mask.
   Assumes the caller invokes tasks just after a rising clk_i edge. */
`timescale 1ns/1ps
module sdr_ctl_model (
    input wire logic clk_i,
    output logic mem_clk_o,
    output logic chip_select_n_o,
    output logic row_strobe_n_o,
    output logic column_strobe_n_o,
    output logic write_enable_n_o,
    output logic clock_enable_pin_o,
    output logic burst_select_address_bit_o,
    output logic [sdr_pkg::DATA_W-1:0] data_o,
    output logic [sdr_pkg::MASK_W-1:0] write_data_mask_o
);
    import sdr_pkg::*;
    initial begin
        mem_clk_o = 1'b0;
        {chip_select_n_o, row_strobe_n_o, column_strobe_n_o} = 3'h7;
        write_enable_n_o = 1'b1;
        clock_enable_pin_o = 1'b1;
        burst_select_address_bit_o = 1'b0;
        data_o = '0;
        write_data_mask_o = '0;
    end
    // One 160 ns memory clock; pins settle while the clock is low
    task tick(input logic [3:0] c, input logic ke, input logic [15:0] d,
        input logic [1:0] m);
        @(posedge clk_i);
        {chip_select_n_o, row_strobe_n_o, column_strobe_n_o} <= c[3:1];
        write_enable_n_o <= c[0];
        clock_enable_pin_o <= ke;
        data_o <= d;
        write_data_mask_o <= m;
        repeat (7) @(posedge clk_i);
        mem_clk_o <= 1'b1;
        repeat (8) @(posedge clk_i);
        mem_clk_o <= 1'b0;
    endtask : tick
    // idle cycles, lines flip so no stale data
    task idle(input int n, input logic ke);
        repeat (n) tick(CMD_NOP, ke, ~data_o, ~write_data_mask_o);
    endtask : idle
    // write, latency, beats, then idle recovery
    task write_burst(input logic sel);
        burst_select_address_bit_o <= sel;
        tick(CMD_WRITE, 1'b1, ~data_o, ~write_data_mask_o);
        idle(WRITE_LAT - 1, 1'b1);
        for (int k = 0; k < 8; k++)
            tick(CMD_NOP, 1'b1, 16'ha500 + k, k[1:0]);
        idle(3, 1'b1);
    endtask : write_burst
endmodule : sdr_ctl_model

// >>> tb/sdr_refresh_properties.sv
/* Port checker for sdr_refresh.
   Assumes one clock domain and the bind at the foot of this file. */
`timescale 1ns/1ps
module sdr_refresh_properties (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic refresh_pulse_o,
    input wire logic [sdr_pkg::ROW_W-1:0] refresh_row_o,
    input wire logic self_refresh_o,
    input wire logic dll_enabled_o,
    input wire logic wr_beat_valid_o
);
    import sdr_pkg::*;
    int gap_reg;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    // Clocks since the last refresh; only grows inside self-refresh
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i)
            gap_reg <= 0;
        else if (refresh_pulse_o || !self_refresh_o)
            gap_reg <= 0;
        else
            gap_reg <= gap_reg + 1;
    end
    a_row_step: assert property ($changed(refresh_row_o) |->
        refresh_row_o == $past(refresh_row_o) + 1'b1) else $error("row skip");
    a_row_with_pulse: assert property ($changed(refresh_row_o) |->
        refresh_pulse_o || $past(refresh_pulse_o)) else $error("row moved");
    a_pulse_gap: assert property (refresh_pulse_o |=>
        !refresh_pulse_o [*8]) else $error("refresh too close");
    a_sr_refresh_soon: assert property ($rose(self_refresh_o) |->
        ##[0:3] refresh_pulse_o) else $error("no refresh on entry");
    a_sr_timer_gap: assert property (gap_reg < REFI_CYC + 8)
        else $error("self-refresh timer stalled");
    a_sr_dll_off: assert property (self_refresh_o && $past(self_refresh_o)
        |-> !dll_enabled_o) else $error("loop on in self-refresh");
    a_exit_relock: assert property ($fell(self_refresh_o) |->
        !dll_enabled_o [*8]) else $error("loop on without reset");
    a_beat_gap: assert property (wr_beat_valid_o |=>
        !wr_beat_valid_o [*8]) else $error("beats too close");
    a_sr_no_beats: assert property (self_refresh_o && $past(self_refresh_o)
        |-> !wr_beat_valid_o) else $error("beat in self-refresh");
    a_status_view: assert property (avs_read && avs_address == OFS_STATUS
        |-> avs_readdata[ST_SELF] == self_refresh_o &&
        avs_readdata[ST_DLL] == dll_enabled_o) else $error("status wrong");
    a_bus_ready: assert property (avs_read || avs_write |->
        !avs_waitrequest) else $error("bus stalled");
endmodule : sdr_refresh_properties
bind sdr_refresh sdr_refresh_properties u_props (.clk_i, .nrst_i, .avs_address,
    .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .refresh_pulse_o,
    .refresh_row_o, .self_refresh_o, .dll_enabled_o, .wr_beat_valid_o);

// >>> tb/tb_sdr_refresh.sv
/* Self-checking bench for sdr_refresh with a controller model.
   Assumes a 100 MHz clock and 160 ns memory clock from the model. */
`timescale 1ns/1ps
module tb_sdr_refresh;
    import sdr_pkg::*;
    logic clk_i = 0, nrst_i = 0, mclk, cs_n, ras_n, cas_n, we_n, cke, bsel;
    logic [15:0] dq;
    logic [1:0] dm;
    logic [3:0] avs_address = 0;
    logic avs_read = 0, avs_write = 0, pulse, sr, dll, bv, avs_waitrequest;
    logic [31:0] avs_writedata = 0, avs_readdata, q, r;
    logic [13:0] row;
    logic [15:0] bd;
    logic [1:0] bm;
    logic [17:0] beat_q[$];
    int fails = 0, check_count = 0, pulses = 0, p, n;
    always #5 clk_i = ~clk_i;
    sdr_ctl_model ctl (.clk_i(clk_i), .mem_clk_o(mclk), .chip_select_n_o(cs_n),
        .row_strobe_n_o(ras_n), .column_strobe_n_o(cas_n), .write_enable_n_o(we_n),
        .clock_enable_pin_o(cke), .burst_select_address_bit_o(bsel),
        .data_o(dq), .write_data_mask_o(dm));
    sdr_refresh dut (.clk_i(clk_i), .nrst_i(nrst_i), .mem_clk_i(mclk),
        .chip_select_n_i(cs_n), .row_strobe_n_i(ras_n), .column_strobe_n_i(cas_n),
        .write_enable_n_i(we_n), .clock_enable_pin_i(cke),
        .burst_select_address_bit_i(bsel), .data_i(dq), .write_data_mask_i(dm),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .refresh_pulse_o(pulse),
        .refresh_row_o(row), .self_refresh_o(sr), .dll_enabled_o(dll),
        .wr_beat_valid_o(bv), .wr_beat_data_o(bd), .wr_beat_mask_o(bm));
    // Tally refreshes and keep every captured beat
    always @(posedge clk_i) begin
        if (pulse === 1'b1) pulses++;
        if (bv === 1'b1) beat_q.push_back({bm, bd});
    end
    task chk_word(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk_word
    task chk_flag(input logic got, input logic exp);
        chk_word({31'h0, got}, {31'h0, exp});
    endtask : chk_flag
    // Avalon cycle held until waitrequest is seen low at a rising edge
    task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge clk_i);
        while (avs_waitrequest !== 1'b0) @(posedge clk_i);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus
    task give_verdict();
        $display("fails %0d checks %0d", fails, check_count);
        if (fails == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict
    // Watchdog well past the expected 160 us run
    initial begin
        #400000;
        fails++;
        give_verdict();
    end
    initial begin
        repeat (16) @(posedge clk_i);
        nrst_i <= 1'b1;
        bus(0, OFS_MODE0, 0); chk_word(q, MODE0_RST);
        bus(0, OFS_MODE1, 0); chk_word(q, MODE1_RST);
        chk_flag(dll, 1'b1);
        bus(1, 4'h6, '1); bus(0, 4'h6, 0); chk_word(q, 0);
        // banks idle, sparse refresh
        // Every command code but write; only the refresh code may count
        for (int i = 0; i < 16; i++) begin
            if (i == CMD_WRITE) continue;
            p = pulses;
            r = row;
            ctl.tick(i[3:0], 1'b1, 16'h0f0f, 2'h1);
            ctl.idle(14, 1'b1);
            chk_word(pulses - p, i == CMD_REFRESH);
            chk_word(row, r + (i == CMD_REFRESH));
            chk_word(beat_q.size(), 0);
        end
        bus(0, OFS_COUNT, 0); chk_word(q, 1);
        // Each burst field code, select bit low then high
        for (int i = 0; i < 6; i++) begin
            bus(1, OFS_MODE0, i >> 1); bus(0, OFS_MODE0, 0);
            chk_word(q[1:0], i >> 1);
            beat_q.delete();
            ctl.write_burst(i[0]);
            n = (i > 3 || i == 2) ? BEATS_CHOP : BEATS_EIGHT;
            chk_word(beat_q.size(), n);
            for (int k = 0; k < n; k++)
                chk_word(beat_q[k], {k[1:0], 16'ha500 + k[15:0]});
        end
        // none owed, termination off
        // Entry with clock enable low, then the memory clock stops
        p = pulses;
        ctl.idle(1, 1'b1);
        ctl.tick(CMD_REFRESH, 1'b0, 16'h0, 2'h0);
        chk_flag(sr, 1'b1);
        chk_flag(dll, 1'b0);
        chk_flag(pulses > p, 1'b1);
        bus(0, OFS_STATUS, 0); chk_flag(q[ST_SELF], 1'b1);
        p = pulses;
        repeat (2000) @(posedge clk_i);
        chk_flag(pulses - p >= 2, 1'b1);
        // clock restarted and stable before exit
        beat_q.delete();
        ctl.tick(CMD_WRITE, 1'b0, 16'h0, 2'h0);
        ctl.idle(14, 1'b0);
        chk_flag(sr, 1'b1);
        chk_word(beat_q.size(), 0);
        ctl.idle(1, 1'b1);
        chk_flag(sr, 1'b0);
        ctl.idle(500, 1'b1);
        chk_flag(dll, 1'b0);
        ctl.idle(20, 1'b1);
        chk_flag(dll, 1'b1);
        p = pulses;
        ctl.tick(CMD_REFRESH, 1'b1, 16'h0, 2'h0);
        ctl.idle(2, 1'b1);
        chk_word(pulses - p, 1);
        bus(1, OFS_MODE1, 1);
        repeat (4) @(posedge clk_i);
        chk_flag(dll, 1'b0);
        give_verdict();
    end
endmodule : tb_sdr_refresh
